// ==== rtl/valve_pkg.sv ====
package valve_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] MODE_OFFSET = 8'h00;
  localparam logic [7:0] CONFIG_OFFSET = 8'h04;
  localparam logic [7:0] SETPOINT_OFFSET = 8'h08;
  localparam logic [7:0] STATUS_OFFSET = 8'h0C;

  // ==========================================================
  // field positions
  localparam int MODE_LSB = 0;
  localparam int DRIVE_LSB = 0;
  localparam int SENSOR_LSB = 4;
  localparam int TREAT_LSB = 8;
  localparam int SP_VALUE_LSB = 0;
  localparam int SP_GOOD_BIT = 8;
  localparam int ST_RETURNED_LSB = 0;
  localparam int ST_POSITION_LSB = 8;
  localparam int ST_PILOT_BIT = 12;
  localparam int ST_MODE_LSB = 16;
  localparam int ST_REFUSED_BIT = 20;
  localparam int ST_MONITOR_BIT = 21;
  localparam int ST_CONTACT_LSB = 24;

  // ==========================================================
  // settings and decoded states
  typedef enum logic [1:0] {MODE_OOS, MODE_AUTO, MODE_MANUAL} mode_t;
  typedef enum logic [1:0] {
    DRIVE_UNDEFINED, DRIVE_SELF_OPENING, DRIVE_SELF_CLOSING
  } drive_t;
  typedef enum logic [2:0] {
    SENSE_NONE, SENSE_RAW, SENSE_OPT_A, SENSE_OPT_B, SENSE_OPT_C, SENSE_OPT_D
  } sensor_t;
  typedef enum logic [2:0] {
    TREAT_CODED, TREAT_EXTENDED, TREAT_INTER_CLOSED, TREAT_INTER_OPEN,
    TREAT_INTER_NEXT, TREAT_INTER_LAST
  } treatment_t;
  typedef enum logic [1:0] {
    POS_CLOSED, POS_INTER, POS_OPEN, POS_UNCERTAIN
  } position_t;

  typedef struct packed {
    drive_t drive;
    sensor_t sensor;
    treatment_t treatment;
  } config_t;

  typedef struct packed {
    logic [7:0] value;
    logic good;
  } setpoint_t;

  // ==========================================================
  // reset values and returned codes
  localparam mode_t MODE_RESET = MODE_OOS;
  localparam config_t CONFIG_RESET = '{DRIVE_UNDEFINED, SENSE_NONE,
                                       TREAT_INTER_LAST};
  localparam setpoint_t SETPOINT_RESET = '{8'h00, 1'b0};
  localparam logic [2:0] SENSOR_MAX = 3'h5;
  localparam logic [2:0] TREAT_MAX = 3'h5;
  localparam logic [7:0] CODE_UNKNOWN = 8'h00;
  localparam logic [7:0] CODE_CLOSED = 8'h01;
  localparam logic [7:0] CODE_OPEN = 8'h02;
  localparam logic [7:0] CODE_INTER_OPENING = 8'h03;
  localparam logic [7:0] CODE_INTER_CLOSING = 8'h04;
  localparam logic [7:0] BIN_CLOSED = 8'h00;
  localparam logic [7:0] BIN_OPEN = 8'h01;

endpackage : valve_pkg

// ==== rtl/contact_pattern_decoder.sv ====
module contact_pattern_decoder
  import valve_pkg::*;
(
  input wire logic [1:0] contacts_in,
  input wire sensor_t sensor_in,
  output position_t position_out
);

  logic [1:0] pattern;

  // ==========================================================
  // pattern is written A then B
  always_comb begin
    pattern = {contacts_in[0], contacts_in[1]};
    position_out = POS_UNCERTAIN;
    unique case (sensor_in)
      SENSE_OPT_A: begin
        unique case (pattern)
          2'h1: position_out = POS_CLOSED;
          2'h0: position_out = POS_INTER;
          2'h2: position_out = POS_OPEN;
          2'h3: position_out = POS_UNCERTAIN;
        endcase
      end
      SENSE_OPT_B: begin
        unique case (pattern)
          2'h2: position_out = POS_CLOSED;
          2'h3: position_out = POS_INTER;
          2'h1: position_out = POS_OPEN;
          2'h0: position_out = POS_UNCERTAIN;
        endcase
      end
      SENSE_OPT_C: begin
        unique case (pattern)
          2'h2: position_out = POS_CLOSED;
          2'h0: position_out = POS_INTER;
          2'h1: position_out = POS_OPEN;
          2'h3: position_out = POS_UNCERTAIN;
        endcase
      end
      SENSE_OPT_D: begin
        unique case (pattern)
          2'h1: position_out = POS_CLOSED;
          2'h3: position_out = POS_INTER;
          2'h2: position_out = POS_OPEN;
          2'h0: position_out = POS_UNCERTAIN;
        endcase
      end
      default: position_out = POS_UNCERTAIN;
    endcase
  end

endmodule : contact_pattern_decoder

// ==== rtl/valve_position_feedback_decoder.sv ====
// Notes on behaviour
// - drive design: undefined, self-opening, self-closing
// - undefined drive design keeps channel out of service
// - drive design writable only in out-of-service target
// - drive design decides pilot valve energising
// - sensor usage, treatment writable only out of service
// - no detection returns commanded reference value
// - raw mode: contact A bit 0, B bit 1
// - high contact current reads as logic one
// - options A and B contact decoding tables
// - options C and D contact decoding tables
// - monitoring features only with options A to D
// - six treatments, intermediate-last is the default
// - coded: 1 closed, 2 open, 3 intermediate
// - extended: 3 opening, 4 closing intermediate
// - direction follows command, not sensed travel
// - binary: 0 closed, 1 open, fixed intermediate
// - next: intermediate shows the target position
// - last: intermediate shows the starting position
// - reference zero closed, 1 to 255 open
// - only good reference adopted, bad de-energises pilot
// - out of service: pilot off, default target mode
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
module valve_position_feedback_decoder
  import valve_pkg::*;
(
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [7:0] address_in,
  input wire logic [31:0] write_data_in,
  input wire logic write_strobe_in,
  input wire logic read_strobe_in,
  output logic [31:0] read_data_out,
  input wire logic contact_a_in,
  input wire logic contact_b_in,
  output logic pilot_valve_out,
  output logic [7:0] returned_position_value_out,
  output mode_t actual_mode_out,
  output logic monitoring_available_out
);

  // ==========================================================
  // contact synchronisers
  logic [1:0] contact_sync1_reg;
  logic [1:0] contact_sync2_reg;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      contact_sync1_reg <= 2'h0;
      contact_sync2_reg <= 2'h0;
    end else begin
      // high current arrives as one, taken as logic one
      contact_sync1_reg <= {contact_b_in, contact_a_in};
      contact_sync2_reg <= contact_sync1_reg;
    end
  end

  // ==========================================================
  // software registers
  mode_t target_mode_reg;
  mode_t target_mode_next;
  config_t config_reg;
  config_t config_next;
  setpoint_t setpoint_reg;
  setpoint_t setpoint_next;
  logic [7:0] adopted_reg;
  logic [7:0] adopted_next;
  logic refused_reg;
  logic refused_next;

  logic mode_write;
  logic config_write;
  logic setpoint_write;
  logic status_read;
  logic mode_legal;
  logic config_legal;
  logic config_refused;
  position_t position;

  contact_pattern_decoder decoder_inst (
    .contacts_in(contact_sync2_reg),
    .sensor_in(config_reg.sensor),
    .position_out(position)
  );

  always_comb begin
    mode_write = write_strobe_in && (address_in == MODE_OFFSET);
    config_write = write_strobe_in && (address_in == CONFIG_OFFSET);
    setpoint_write = write_strobe_in && (address_in == SETPOINT_OFFSET);
    status_read = read_strobe_in && (address_in == STATUS_OFFSET);
    mode_legal = write_data_in[MODE_LSB +: 2] != 2'h3;
    config_legal = (write_data_in[DRIVE_LSB +: 2] != 2'h3) &&
                   (write_data_in[SENSOR_LSB +: 3] <= SENSOR_MAX) &&
                   (write_data_in[TREAT_LSB +: 3] <= TREAT_MAX);
    config_refused = config_write &&
                     ((target_mode_reg != MODE_OOS) || !config_legal);

    target_mode_next = target_mode_reg;
    config_next = config_reg;
    setpoint_next = setpoint_reg;
    adopted_next = adopted_reg;
    refused_next = refused_reg;

    if (mode_write && mode_legal) begin
      target_mode_next = mode_t'(write_data_in[MODE_LSB +: 2]);
    end
    // settings change only while the target mode is out of service
    if (config_write && !config_refused) begin
      config_next.drive = drive_t'(write_data_in[DRIVE_LSB +: 2]);
      config_next.sensor = sensor_t'(write_data_in[SENSOR_LSB +: 3]);
      config_next.treatment =
        treatment_t'(write_data_in[TREAT_LSB +: 3]);
    end
    if (setpoint_write) begin
      setpoint_next.value = write_data_in[SP_VALUE_LSB +: 8];
      setpoint_next.good = write_data_in[SP_GOOD_BIT];
      if (write_data_in[SP_GOOD_BIT]) begin
        adopted_next = write_data_in[SP_VALUE_LSB +: 8];
      end
    end
    // a refusal in the clearing read still leaves the flag set
    if (status_read) begin
      refused_next = 1'b0;
    end
    if (config_refused) begin
      refused_next = 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      target_mode_reg <= MODE_RESET;
      config_reg <= CONFIG_RESET;
      setpoint_reg <= SETPOINT_RESET;
      adopted_reg <= 8'h00;
      refused_reg <= 1'b0;
    end else begin
      target_mode_reg <= target_mode_next;
      config_reg <= config_next;
      setpoint_reg <= setpoint_next;
      adopted_reg <= adopted_next;
      refused_reg <= refused_next;
    end
  end

  // ==========================================================
  // mode, pilot valve and returned value
  mode_t actual_mode_next;
  logic pilot_next;
  logic [7:0] returned_next;
  logic monitor_next;
  logic command_open;
  logic decoding;

  always_comb begin
    command_open = adopted_reg != 8'h00;
    decoding = config_reg.sensor inside {SENSE_OPT_A, SENSE_OPT_B,
                                         SENSE_OPT_C, SENSE_OPT_D};
    monitor_next = decoding;

    actual_mode_next = target_mode_reg;
    if (config_reg.drive == DRIVE_UNDEFINED) begin
      actual_mode_next = MODE_OOS;
    end

    // self-opening opens unpowered, so it is energised to close
    pilot_next = 1'b0;
    if (actual_mode_next != MODE_OOS && setpoint_reg.good) begin
      pilot_next = (setpoint_reg.value != 8'h00) ^
                   (config_reg.drive == DRIVE_SELF_OPENING);
    end

    returned_next = CODE_UNKNOWN;
    unique case (config_reg.sensor)
      SENSE_NONE: returned_next = adopted_reg;
      SENSE_RAW: returned_next = {6'h00, contact_sync2_reg};
      default: begin
        // direction comes from the command, not from the contacts
        unique case (config_reg.treatment)
          TREAT_CODED: begin
            unique case (position)
              POS_CLOSED: returned_next = CODE_CLOSED;
              POS_OPEN: returned_next = CODE_OPEN;
              POS_INTER: returned_next = CODE_INTER_OPENING;
              POS_UNCERTAIN: returned_next = CODE_UNKNOWN;
            endcase
          end
          TREAT_EXTENDED: begin
            unique case (position)
              POS_CLOSED: returned_next = CODE_CLOSED;
              POS_OPEN: returned_next = CODE_OPEN;
              POS_INTER: returned_next = command_open ?
                CODE_INTER_OPENING : CODE_INTER_CLOSING;
              POS_UNCERTAIN: returned_next = CODE_UNKNOWN;
            endcase
          end
          default: begin
            unique case (position)
              POS_OPEN: returned_next = BIN_OPEN;
              POS_INTER: begin
                unique case (config_reg.treatment)
                  TREAT_INTER_OPEN: returned_next = BIN_OPEN;
                  TREAT_INTER_NEXT: returned_next = command_open ?
                    BIN_OPEN : BIN_CLOSED;
                  TREAT_INTER_LAST: returned_next = command_open ?
                    BIN_CLOSED : BIN_OPEN;
                  default: returned_next = BIN_CLOSED;
                endcase
              end
              default: returned_next = BIN_CLOSED;
            endcase
          end
        endcase
      end
    endcase
  end

  logic pilot_reg;
  logic [7:0] returned_reg;
  mode_t actual_mode_reg;
  logic monitor_reg;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pilot_reg <= 1'b0;
      returned_reg <= CODE_UNKNOWN;
      actual_mode_reg <= MODE_OOS;
      monitor_reg <= 1'b0;
    end else begin
      pilot_reg <= pilot_next;
      returned_reg <= returned_next;
      actual_mode_reg <= actual_mode_next;
      monitor_reg <= monitor_next;
    end
  end

  assign pilot_valve_out = pilot_reg;
  assign returned_position_value_out = returned_reg;
  assign actual_mode_out = actual_mode_reg;
  assign monitoring_available_out = monitor_reg;

  // ==========================================================
  // read port
  logic [31:0] read_data_reg;
  logic [31:0] read_data_next;

  always_comb begin
    read_data_next = 32'h0000_0000;
    if (read_strobe_in) begin
      unique case (address_in)
        MODE_OFFSET: read_data_next[MODE_LSB +: 2] = target_mode_reg;
        CONFIG_OFFSET: begin
          read_data_next[DRIVE_LSB +: 2] = config_reg.drive;
          read_data_next[SENSOR_LSB +: 3] = config_reg.sensor;
          read_data_next[TREAT_LSB +: 3] = config_reg.treatment;
        end
        SETPOINT_OFFSET: begin
          read_data_next[SP_VALUE_LSB +: 8] = setpoint_reg.value;
          read_data_next[SP_GOOD_BIT] = setpoint_reg.good;
        end
        STATUS_OFFSET: begin
          read_data_next[ST_RETURNED_LSB +: 8] = returned_reg;
          read_data_next[ST_POSITION_LSB +: 2] = position;
          read_data_next[ST_PILOT_BIT] = pilot_reg;
          read_data_next[ST_MODE_LSB +: 2] = actual_mode_reg;
          read_data_next[ST_REFUSED_BIT] = refused_reg;
          read_data_next[ST_MONITOR_BIT] = monitor_reg;
          read_data_next[ST_CONTACT_LSB +: 2] = contact_sync2_reg;
        end
        default: read_data_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      read_data_reg <= 32'h0000_0000;
    end else begin
      read_data_reg <= read_data_next;
    end
  end

  assign read_data_out = read_data_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  sequence s_locked_config_write;
    config_write && (target_mode_reg != MODE_OOS);
  endsequence

  sequence s_refused_then_held;
    ##1 (refused_reg && $stable(config_reg));
  endsequence

  a_config_write_lock: assert property (
    s_locked_config_write |-> s_refused_then_held)
    else $error("settings changed outside out-of-service");

  a_undefined_stays_oos: assert property (
    (config_reg.drive == DRIVE_UNDEFINED) |=> actual_mode_out == MODE_OOS)
    else $error("channel left out-of-service with undefined drive");

  a_oos_pilot_off: assert property (
    (actual_mode_out == MODE_OOS) |-> !pilot_valve_out)
    else $error("pilot energised while out of service");

  a_bad_status_off: assert property (
    !setpoint_reg.good |=> !pilot_valve_out)
    else $error("pilot energised on a bad reference");

  a_pilot_drive_sense: assert property (
    (target_mode_reg != MODE_OOS && setpoint_reg.good &&
     config_reg.drive == DRIVE_SELF_CLOSING) |=>
    pilot_valve_out == ($past(setpoint_reg.value) != 8'h00))
    else $error("pilot does not follow self-closing drive");

  a_raw_contacts: assert property (
    (config_reg.sensor == SENSE_RAW) |=>
    returned_position_value_out == {6'h00, $past(contact_sync2_reg)})
    else $error("raw contact bits misplaced");

  a_no_detect_value: assert property (
    (config_reg.sensor == SENSE_NONE) |=>
    returned_position_value_out == $past(adopted_reg))
    else $error("reference not returned without detection");

  a_coded_uncertain: assert property (
    (decoding && config_reg.treatment == TREAT_CODED &&
     position == POS_UNCERTAIN) |=>
    returned_position_value_out == CODE_UNKNOWN)
    else $error("uncertain not reported as unknown");

  a_extended_closing: assert property (
    (decoding && config_reg.treatment == TREAT_EXTENDED &&
     position == POS_INTER && !command_open) |=>
    returned_position_value_out == CODE_INTER_CLOSING)
    else $error("closing intermediate code wrong");

  a_last_closing: assert property (
    (decoding && config_reg.treatment == TREAT_INTER_LAST &&
     position == POS_INTER && !command_open) |=>
    returned_position_value_out == BIN_OPEN)
    else $error("last treatment wrong while closing");

  a_read_one_cycle: assert property (
    read_strobe_in ##1 !read_strobe_in |=> read_data_out == 32'h0000_0000)
    else $error("read data held beyond one cycle");

endmodule : valve_position_feedback_decoder

// ==== bench/valve_model.sv ====
// ==========================================================
// far side: two feedback contacts and the receiving block
module valve_model
(
  input wire logic clock_in,
  input wire logic [1:0] pattern_in,
  input wire logic [3:0] lag_in,
  input wire logic [7:0] returned_in,
  output logic contact_a_out,
  output logic contact_b_out,
  output logic inverted_out
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [3:0] wait_reg = 4'h0;
  logic [1:0] contacts_reg = 2'h0;

  // ==========================================================
  // contacts settle on the new pattern lag_in + 1 cycles after it changes
  always @(posedge clock_in) begin
    if (contacts_reg == pattern_in) begin
      wait_reg <= 4'h0;
    end else if (wait_reg < lag_in) begin
      wait_reg <= wait_reg + 4'h1;
    end else begin
      contacts_reg <= pattern_in;
      wait_reg <= 4'h0;
    end
  end

  // bit 0 carries contact A, bit 1 contact B
  assign contact_a_out = contacts_reg[0];
  assign contact_b_out = contacts_reg[1];

  // receiver with inversion enabled
  assign inverted_out = (returned_in == 8'h00);
endmodule : valve_model

// ==== bench/testbench.sv ====
`define CHECK(got, exp) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("ERROR %0t got %h want %h", $time, got, exp); \
    end \
  end

module testbench
  import valve_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic [7:0] address = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic ws = 1'b0;
  logic rs = 1'b0;
  logic [31:0] rdata;
  logic pilot;
  logic [7:0] ret;
  mode_t amode;
  logic mon;
  logic ca;
  logic cb;
  logic inv;
  logic [1:0] pattern = 2'h0;
  logic [3:0] lag = 4'h0;
  logic [31:0] got;
  int mismatches = 0;
  int checks = 0;

  initial forever #2.5 clock_in = ~clock_in;

  valve_position_feedback_decoder DUT (
    .clock_in(clock_in), .reset_in(reset_in), .address_in(address),
    .write_data_in(wdata), .write_strobe_in(ws), .read_strobe_in(rs),
    .read_data_out(rdata), .contact_a_in(ca), .contact_b_in(cb),
    .pilot_valve_out(pilot), .returned_position_value_out(ret),
    .actual_mode_out(amode), .monitoring_available_out(mon));

  // one model per channel
  valve_model partner (
    .clock_in(clock_in), .pattern_in(pattern), .lag_in(lag),
    .returned_in(ret), .contact_a_out(ca), .contact_b_out(cb),
    .inverted_out(inv));

  // ==========================================================
  // helpers
  task close_out;
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    ws <= 1'b1;
    address <= a;
    wdata <= d;
    @(posedge clock_in);
    ws <= 1'b0;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    rs <= 1'b1;
    address <= a;
    @(posedge clock_in);
    rs <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task settle;
    repeat (10) @(posedge clock_in);
    #1;
  endtask : settle

  task wait_mode(input mode_t m);
    for (int n = 0; n < 20 && amode !== m; n++) begin
      @(posedge clock_in);
      #1;
    end
    if (amode !== m) begin
      mismatches++;
      $display("ERROR %0t mode wait expired", $time);
      close_out();
    end
  endtask : wait_mode

  function logic [31:0] cfg(drive_t d, sensor_t s, treatment_t t);
    return {21'h0, t, 1'b0, s, 2'b00, d};
  endfunction : cfg

  // packed tables, two bits of position per contact pattern
  function position_t decode(sensor_t s, logic [1:0] p);
    logic [7:0] tbl;
    case (s)
      SENSE_OPT_A: tbl = 8'hC9;
      SENSE_OPT_B: tbl = 8'h63;
      SENSE_OPT_C: tbl = 8'hE1;
      default: tbl = 8'h4B;
    endcase
    return position_t'(tbl[{p, 1'b0} +: 2]);
  endfunction : decode

  function logic [7:0] expect_ret(treatment_t t, position_t p, logic op);
    logic coded;
    coded = (t == TREAT_CODED) || (t == TREAT_EXTENDED);
    case (p)
      POS_CLOSED: return coded ? CODE_CLOSED : BIN_CLOSED;
      POS_OPEN: return coded ? CODE_OPEN : BIN_OPEN;
      POS_UNCERTAIN: return coded ? CODE_UNKNOWN : BIN_CLOSED;
      default: begin
        case (t)
          TREAT_CODED: return 8'h03;
          TREAT_EXTENDED: return op ? CODE_INTER_OPENING : CODE_INTER_CLOSING;
          TREAT_INTER_CLOSED: return BIN_CLOSED;
          TREAT_INTER_OPEN: return BIN_OPEN;
          TREAT_INTER_NEXT: return op ? BIN_OPEN : BIN_CLOSED;
          default: return op ? BIN_CLOSED : BIN_OPEN;
        endcase
      end
    endcase
  endfunction : expect_ret

  // ==========================================================
  // scenarios
  task check_reset;
    rd(MODE_OFFSET, got);
    `CHECK(got, 32'h0)
    rd(CONFIG_OFFSET, got);
    `CHECK(got, 32'h0000_0500)
    rd(SETPOINT_OFFSET, got);
    `CHECK(got, 32'h0)
    `CHECK({pilot, amode, mon, ret}, 12'h000)
    rd(8'h10, got);
    `CHECK(got, 32'h0)
  endtask : check_reset

  task check_mode_gate;
    wr(MODE_OFFSET, 32'h1);
    settle();
    `CHECK(amode, MODE_OOS)
    wr(CONFIG_OFFSET, cfg(DRIVE_SELF_CLOSING, SENSE_RAW, TREAT_CODED));
    rd(STATUS_OFFSET, got);
    `CHECK(got[ST_REFUSED_BIT], 1'b1)
    rd(STATUS_OFFSET, got);
    `CHECK(got[ST_REFUSED_BIT], 1'b0)
    rd(CONFIG_OFFSET, got);
    `CHECK(got, 32'h0000_0500)
    wr(MODE_OFFSET, 32'h0);
    wr(MODE_OFFSET, 32'h3);
    rd(MODE_OFFSET, got);
    `CHECK(got, 32'h0)
    wr(CONFIG_OFFSET, 32'h3);
    rd(STATUS_OFFSET, got);
    `CHECK(got[ST_REFUSED_BIT], 1'b1)
  endtask : check_mode_gate

  task check_pilot;
    drive_t d;
    logic [7:0] vals [3];
    logic e;
    vals = '{8'h00, 8'h01, 8'hFF};
    for (int k = 0; k < 2; k++) begin
      d = k ? DRIVE_SELF_OPENING : DRIVE_SELF_CLOSING;
      wr(MODE_OFFSET, 32'h0);
      wr(CONFIG_OFFSET, cfg(d, SENSE_NONE, TREAT_INTER_LAST));
      wr(MODE_OFFSET, k ? 32'h2 : 32'h1);
      wait_mode(k ? MODE_MANUAL : MODE_AUTO);
      for (int i = 0; i < 3; i++) begin
        e = (vals[i] != 8'h00) ^ (d == DRIVE_SELF_OPENING);
        wr(SETPOINT_OFFSET, {23'h0, 1'b1, vals[i]});
        settle();
        `CHECK(pilot, e)
        `CHECK(ret, vals[i])
        `CHECK(inv, vals[i] == 8'h00)
      end
      wr(SETPOINT_OFFSET, {23'h0, 1'b0, 8'h01});
      settle();
      `CHECK(pilot, 1'b0)
      `CHECK(ret, 8'hFF)
      wr(SETPOINT_OFFSET, {23'h0, 1'b1, 7'h0, ~k[0]});
      settle();
      `CHECK(pilot, 1'b1)
      wr(MODE_OFFSET, 32'h0);
      settle();
      `CHECK({amode, pilot}, 3'h0)
    end
  endtask : check_pilot

  task check_raw;
    wr(CONFIG_OFFSET, cfg(DRIVE_SELF_CLOSING, SENSE_RAW, TREAT_CODED));
    for (int p = 0; p < 4; p++) begin
      @(posedge clock_in);
      pattern <= p[1:0];
      settle();
      `CHECK(ret, {6'h00, p[1:0]})
      `CHECK(mon, 1'b0)
    end
  endtask : check_raw

  task check_decode;
    logic [7:0] e;
    for (int s = 2; s < 6; s++) begin
      for (int t = 0; t < 6; t++) begin
        for (int dir = 0; dir < 2; dir++) begin
          wr(CONFIG_OFFSET,
             cfg(DRIVE_SELF_CLOSING, sensor_t'(s), treatment_t'(t)));
          wr(SETPOINT_OFFSET, {23'h0, 1'b1, 7'h0, dir[0]});
          for (int p = 0; p < 4; p++) begin
            @(posedge clock_in);
            pattern <= p[1:0];
            lag <= {2'b00, s[1:0]};
            settle();
            e = expect_ret(treatment_t'(t), decode(sensor_t'(s), p[1:0]),
                           dir[0]);
            `CHECK(ret, e)
            `CHECK(mon, 1'b1)
          end
        end
      end
    end
  endtask : check_decode

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(posedge clock_in);
    reset_in <= 1'b0;
    check_reset();
    check_mode_gate();
    check_pilot();
    check_raw();
    check_decode();
    close_out();
  end

  initial begin
    #400us;
    mismatches++;
    $display("ERROR %0t run limit reached", $time);
    close_out();
  end
endmodule : testbench
